// file: rtl/ead_pkg.sv
// Purpose: constants shared by the external area decoder
// Assumes: 16-bit registers at byte addresses equal to four times their index
// Notes:   register slots follow the order of REG_IDX
package ead_pkg;
   localparam int AW      = 32;
   localparam int DW      = 32;
   localparam int RW      = 16;
   localparam int REG_NUM = 18;

   // ------------------------------------------------------------
   // register indices (byte address = 4 x index) and reset values
   // ------------------------------------------------------------
   localparam logic [31:0] REG_IDX [REG_NUM] = '{
      32'hFFFFFF50, 32'hFFFFFF52, 32'hFFFFFF54, 32'h0FFFFF56,
      32'h0FFFFF58, 32'h0FFFFF5A, 32'h0FFFFF5C, 32'hFFFFFF5E,
      32'hFFFFFF60, 32'hFFFFFF62, 32'hFFFFFF64, 32'hFFFFFF66,
      32'hFFFFFF68, 32'h0FFFFF6C, 32'hFFFFFF6E, 32'hFFFFFF70,
      32'hFFFFFF72, 32'hFFFFFF74};
   localparam logic [15:0] REG_RST [REG_NUM] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h3FF0, 16'h3FF3, 16'hFFFF,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam int SLOT_ROM_SEL0 = 0;
   localparam int SLOT_BUS_CTRL_TWO = 9;
   localparam int SLOT_MEM_TYPE = 12;
   localparam int SLOT_CARD_IF  = 13;
   localparam int MROM_NUM      = 8;

   // sdram mode register windows, 4K indices each
   localparam logic [31:0] SDM2_IDX    = 32'hFFFFD000;
   localparam logic [31:0] SDM3_IDX    = 32'hFFFFE000;
   localparam int          SDM_WIN_LSB = 12;

   // ------------------------------------------------------------
   // address fields and codes
   // ------------------------------------------------------------
   localparam int AREA_MSB = 28;
   localparam int AREA_LSB = 26;
   localparam int HALF_BIT = 25;
   localparam logic [2:0] AREA_IO  = 3'h1;
   localparam logic [2:0] AREA_RSV = 3'h7;
   localparam logic [2:0] AREA_C5  = 3'h5;
   localparam logic [2:0] AREA_C6  = 3'h6;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] W_LONG  = 2'h3;
   localparam logic [1:0] MT_NORM  = 2'h0;
   localparam logic [1:0] MT_BURST = 2'h1;
   localparam logic [1:0] MT_SDRAM = 2'h2;
   localparam logic [1:0] MT_CARD  = 2'h3;

   // memory type bits, card bits, mask rom select fields
   localparam int MT_BURST0_BIT = 0;
   localparam int MT_SDRAM2_BIT = 1;
   localparam int MT_SDRAM3_BIT = 2;
   localparam int MT_BURST5_BIT = 3;
   localparam int MT_BURST6_BIT = 4;
   localparam int CARD5_BIT     = 0;
   localparam int CARD6_BIT     = 1;
   localparam int MROM_EN_BIT   = 0;
   localparam int MROM_A2_BIT   = 1;
   localparam int MROM_SL_MSB   = 25;
   localparam int MROM_SL_LSB   = 23;

   // width straps settle this many cycles after reset release
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage : ead_pkg

// file: rtl/ead_area_dec.sv
// Purpose: combinational area decode of a physical address
// Assumes: address bits 31 to 29 carry no meaning here
// Notes:   outputs are gated by the caller with its access valid
`timescale 1ns/1ps
module ead_area_dec
   import ead_pkg::*;
(
   // access
   input  wire logic [ead_pkg::AW-1:0] addr,
   input  wire logic [1:0]             size,
   input  wire logic                   card5,
   input  wire logic                   card6,
   // decode
   output logic      [2:0]             area,
   output logic      [6:0]             cs_n,
   output logic      [1:0]             ce2_n,
   output logic                        internal
);
   wire upper_lane;

   assign area       = addr[AREA_MSB:AREA_LSB];
   assign internal   = (area == AREA_IO) || (area == AREA_RSV);
   assign upper_lane = (size != SZ_BYTE) || addr[0];

   for (genvar i = 0; i < 7; i++) begin : g_cs
      assign cs_n[i] = ~((area == 3'(i)) && !internal);
   end

   assign ce2_n[0] = ~((area == AREA_C5) && card5 && upper_lane);
   assign ce2_n[1] = ~((area == AREA_C6) && card6 && upper_lane);
endmodule : ead_area_dec

// file: rtl/ead_top.sv
// Purpose: external area decoder with apb register file
// Assumes: access requests come from logic on sys_clk
// Notes:   all pin outputs are registered one cycle after the request
//
// What this block does
// - area code is physical address bits 28 to 26, 000 area 0, 110 area 6
// - address bits 31 to 29 never affect the area choice
// - base plus n times 0x20000000 reaches the same area
// - each area's low-active select asserts only during its access
// - card areas 5 and 6 also assert the card enable of touched upper lane
// - areas 0 to 4 span 64 Mbytes; areas 5 and 6 two 32 Mbyte halves
// - area 0 width comes from two straps at reset; 00 is never presented
// - areas 2 to 6 take their width from bus control register two
// - registers take initial values only at power-on reset
// - writes in a 4K window per sdram area set its mode register
// - area 0 burst, 2 and 3 sdram, 5 and 6 burst or card
// - mask rom selects serve devices on area 0 or area 2
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module ead_top (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [ead_pkg::AW-1:0] paddr,
   input  wire logic [ead_pkg::DW-1:0] pwdata,
   output logic      [ead_pkg::DW-1:0] prdata,
   output logic                        pready,
   output logic                        pslverr,
   // access request
   input  wire logic                   acc_valid,
   input  wire logic [ead_pkg::AW-1:0] acc_addr,
   input  wire logic [1:0]             acc_size,
   // width straps
   input  wire logic                   width_strap_hi,
   input  wire logic                   width_strap_lo,
   // selects
   output logic                        chip_select_area0_n,
   output logic                        chip_select_area2_n,
   output logic                        chip_select_area3_n,
   output logic                        chip_select_area4_n,
   output logic                        chip_select_area5_n,
   output logic                        chip_select_area6_n,
   output logic                        card_enable_hi_a_n,
   output logic                        card_enable_hi_b_n,
   output logic      [7:0]             mask_rom_selects_n,
   // access attributes
   output logic      [2:0]             acc_area,
   output logic      [1:0]             acc_bus_width,
   output logic      [1:0]             acc_mem_type,
   output logic                        acc_upper_half,
   output logic                        acc_internal,
   // sdram mode set
   output logic                        sdram_mode_set_area2,
   output logic                        sdram_mode_set_area3,
   output logic      [7:0]             sdram_mode_data
);
   import ead_pkg::*;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic idx_hit(input logic [AW-1:0] a,
                                    input logic [31:0] idx,
                                    input int lsb);
      logic [29:0] w;
      logic [29:0] i;
      w = a[31:2];
      i = idx[29:0];
      return (w >> lsb) == (i >> lsb);
   endfunction : idx_hit

   function automatic logic [1:0] width_sel(input logic [2:0] ar,
                                            input logic [15:0] bcr,
                                            input logic [1:0] w0);
      logic [1:0] w;
      w = W_LONG;
      if (ar == 3'h0) begin
         w = w0;
      end else if (ar >= 3'h2 && ar <= AREA_C6) begin
         w = bcr[{ar, 1'b0} +: 2];
      end
      return w;
   endfunction : width_sel

   function automatic logic [1:0] type_sel(input logic [2:0] ar,
                                           input logic [15:0] mt,
                                           input logic [15:0] cd);
      logic [1:0] t;
      t = MT_NORM;
      unique case (ar)
         3'h0: if (mt[MT_BURST0_BIT]) t = MT_BURST;
         3'h2: if (mt[MT_SDRAM2_BIT]) t = MT_SDRAM;
         3'h3: if (mt[MT_SDRAM3_BIT]) t = MT_SDRAM;
         3'h5: t = cd[CARD5_BIT] ? MT_CARD : (mt[MT_BURST5_BIT] ? MT_BURST : MT_NORM);
         3'h6: t = cd[CARD6_BIT] ? MT_CARD : (mt[MT_BURST6_BIT] ? MT_BURST : MT_NORM);
         default: t = MT_NORM;
      endcase
      return t;
   endfunction : type_sel

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   logic [RW-1:0]      regs_q [REG_NUM];
   logic [REG_NUM-1:0] hit;
   logic [RW-1:0]      rd_d;
   logic               pready_q;
   logic               pslverr_q;
   logic [DW-1:0]      prdata_q;
   logic               sdm2_q;
   logic               sdm3_q;
   logic [7:0]         sdm_data_q;
   wire                acc_ph;
   wire                commit;
   wire                in_sdm2;
   wire                in_sdm3;
   wire                mapped;

   for (genvar i = 0; i < REG_NUM; i++) begin : g_hit
      assign hit[i] = idx_hit(paddr, REG_IDX[i], 0);
   end

   assign in_sdm2 = idx_hit(paddr, SDM2_IDX, SDM_WIN_LSB);
   assign in_sdm3 = idx_hit(paddr, SDM3_IDX, SDM_WIN_LSB);
   assign mapped  = (|hit) || in_sdm2 || in_sdm3;
   assign acc_ph  = psel && penable;
   assign commit  = acc_ph && pready_q;

   always_comb begin
      rd_d = '0;
      for (int i = 0; i < REG_NUM; i++) begin
         if (hit[i]) begin
            rd_d = regs_q[i];
         end
      end
   end

   // one wait cycle: answer comes in the second access cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else begin
         pready_q  <= acc_ph && !pready_q;
         pslverr_q <= acc_ph && !pready_q && !mapped;
         if (acc_ph && !pready_q) begin
            prdata_q <= pwrite ? '0 : {16'h0000, rd_d};
         end
      end
   end

   // registers only reset by power-on reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < REG_NUM; i++) begin
            regs_q[i] <= REG_RST[i];
         end
      end else begin
         for (int i = 0; i < REG_NUM; i++) begin
            if (commit && pwrite && hit[i]) begin
               regs_q[i] <= pwdata[RW-1:0];
            end
         end
      end
   end

   // byte-wide write-only mode set, one-cycle pulse per write
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sdm2_q     <= 1'b0;
         sdm3_q     <= 1'b0;
         sdm_data_q <= 8'h00;
      end else begin
         sdm2_q <= commit && pwrite && in_sdm2;
         sdm3_q <= commit && pwrite && in_sdm3;
         if (commit && pwrite && (in_sdm2 || in_sdm3)) begin
            sdm_data_q <= pwdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // width straps
   // ------------------------------------------------------------
   logic [1:0] strap_s1_q;
   logic [1:0] strap_s2_q;
   logic [1:0] strap_cnt_q;
   logic       strap_done_q;
   logic [1:0] area0_w_q;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_s1_q <= 2'h0;
         strap_s2_q <= 2'h0;
      end else begin
         strap_s1_q <= {width_strap_hi, width_strap_lo};
         strap_s2_q <= strap_s1_q;
      end
   end

   // caught once after release, once the synchroniser has settled
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_cnt_q  <= 2'h0;
         strap_done_q <= 1'b0;
         area0_w_q    <= W_LONG;
      end else if (!strap_done_q) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == STRAP_SETTLE) begin
            area0_w_q    <= strap_s2_q;
            strap_done_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // area decode and select outputs
   // ------------------------------------------------------------
   logic [2:0]  dec_area;
   logic [6:0]  dec_cs_n;
   logic [1:0]  dec_ce2_n;
   logic        dec_int;
   logic [6:0]  cs_n_q;
   logic [1:0]  ce2_n_q;
   logic [7:0]  mrom_n_q;
   logic [2:0]  area_q;
   logic [1:0]  width_q;
   logic [1:0]  type_q;
   logic        half_q;
   logic        int_q;
   logic [7:0]  mrom_hit;
   wire  [15:0] card_reg;
   wire  [2:0]  slice;

   assign card_reg = regs_q[SLOT_CARD_IF];
   assign slice    = acc_addr[MROM_SL_MSB:MROM_SL_LSB];

   ead_area_dec u_dec (
      .addr     (acc_addr),
      .size     (acc_size),
      .card5    (card_reg[CARD5_BIT]),
      .card6    (card_reg[CARD6_BIT]),
      .area     (dec_area),
      .cs_n     (dec_cs_n),
      .ce2_n    (dec_ce2_n),
      .internal (dec_int)
   );

   for (genvar n = 0; n < MROM_NUM; n++) begin : g_mrom
      assign mrom_hit[n] = regs_q[SLOT_ROM_SEL0 + n][MROM_EN_BIT]
                        && (dec_area == {1'b0, regs_q[SLOT_ROM_SEL0 + n][MROM_A2_BIT], 1'b0})
                        && (slice == 3'(n));
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_n_q   <= 7'h7F;
         ce2_n_q  <= 2'h3;
         mrom_n_q <= 8'hFF;
         area_q   <= 3'h0;
         width_q  <= 2'h0;
         type_q   <= MT_NORM;
         half_q   <= 1'b0;
         int_q    <= 1'b0;
      end else begin
         cs_n_q   <= dec_cs_n | {7{!acc_valid}};
         ce2_n_q  <= dec_ce2_n | {2{!acc_valid}};
         mrom_n_q <= ~(mrom_hit & {8{acc_valid}});
         area_q   <= acc_valid ? dec_area : 3'h0;
         width_q  <= acc_valid ? width_sel(dec_area, regs_q[SLOT_BUS_CTRL_TWO], area0_w_q)
                               : 2'h0;
         type_q   <= acc_valid ? type_sel(dec_area, regs_q[SLOT_MEM_TYPE], card_reg)
                               : MT_NORM;
         half_q   <= acc_valid && dec_area >= AREA_C5 && acc_addr[HALF_BIT];
         int_q    <= acc_valid && dec_int;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata               = prdata_q;
   assign pready               = pready_q;
   assign pslverr              = pslverr_q;
   assign chip_select_area0_n  = cs_n_q[0];
   assign chip_select_area2_n  = cs_n_q[2];
   assign chip_select_area3_n  = cs_n_q[3];
   assign chip_select_area4_n  = cs_n_q[4];
   assign chip_select_area5_n  = cs_n_q[5];
   assign chip_select_area6_n  = cs_n_q[6];
   assign card_enable_hi_a_n   = ce2_n_q[0];
   assign card_enable_hi_b_n   = ce2_n_q[1];
   assign mask_rom_selects_n   = mrom_n_q;
   assign acc_area             = area_q;
   assign acc_bus_width        = width_q;
   assign acc_mem_type         = type_q;
   assign acc_upper_half       = half_q;
   assign acc_internal         = int_q;
   assign sdram_mode_set_area2 = sdm2_q;
   assign sdram_mode_set_area3 = sdm3_q;
   assign sdram_mode_data      = sdm_data_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   logic por_seen_q;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         por_seen_q <= 1'b0;
      end else begin
         por_seen_q <= 1'b1;
      end
   end

   sequence s_sdm2_write;
      commit && pwrite && in_sdm2;
   endsequence

   sequence s_mode_pulse;
      sdram_mode_set_area2 ##1 !sdram_mode_set_area2;
   endsequence

   property p_area_code;
      acc_valid |=> acc_area == $past(acc_addr[28:26]);
   endproperty
   a_area_code: assert property (p_area_code) else $error("area code mismatch");

   property p_high_bits;
      acc_valid && $stable(acc_addr[28:0]) && !$stable(acc_addr[31:29])
         && $past(acc_valid) |=> $stable(cs_n_q);
   endproperty
   a_high_bits: assert property (p_high_bits) else $error("high bits changed select");

   property p_area0_cs;
      acc_valid && acc_addr[28:26] == 3'h0 |=> !chip_select_area0_n && mask_rom_selects_n[7:0] != 8'h00;
   endproperty
   a_area0_cs: assert property (p_area0_cs) else $error("area 0 select missing");

   property p_one_select;
      $countones(~cs_n_q) <= 1 and (!acc_valid |=> cs_n_q == 7'h7F);
   endproperty
   a_one_select: assert property (p_one_select) else $error("select not exclusive");

   property p_card_lane;
      acc_valid && acc_addr[28:26] == AREA_C6 && card_reg[CARD6_BIT] && acc_size != SZ_BYTE
         |=> !card_enable_hi_b_n && !chip_select_area6_n && acc_mem_type == MT_CARD;
   endproperty
   a_card_lane: assert property (p_card_lane) else $error("card enable missing");

   property p_half;
      acc_valid && acc_addr[28:26] == AREA_C5 |=> acc_upper_half == $past(acc_addr[25]);
   endproperty
   a_half: assert property (p_half) else $error("half flag wrong");

   property p_strap;
      $rose(strap_done_q) |-> area0_w_q == $past(strap_s2_q) ##1 $stable(area0_w_q)[*3];
   endproperty
   a_strap: assert property (p_strap) else $error("strap width not held");

   property p_width;
      acc_valid && acc_addr[28:26] == 3'h4
         |=> acc_bus_width == $past(regs_q[SLOT_BUS_CTRL_TWO][9:8]);
   endproperty
   a_width: assert property (p_width) else $error("area 4 width wrong");

   property p_reset_vals;
      !por_seen_q |-> regs_q[SLOT_BUS_CTRL_TWO] == 16'h3FF0 && regs_q[11] == 16'hFFFF;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad initial value");

   property p_mode_set;
      s_sdm2_write |=> s_mode_pulse and sdram_mode_data == $past(pwdata[7:0]);
   endproperty
   a_mode_set: assert property (p_mode_set) else $error("mode set missing");

   property p_mrom_area;
      acc_valid && acc_addr[28:26] != 3'h0 && acc_addr[28:26] != 3'h2
         |=> mask_rom_selects_n == 8'hFF;
   endproperty
   a_mrom_area: assert property (p_mrom_area) else $error("mask rom outside area");

   property p_internal;
      acc_valid && (acc_addr[28:26] == AREA_IO || acc_addr[28:26] == AREA_RSV)
         |=> cs_n_q == 7'h7F && acc_internal;
   endproperty
   a_internal: assert property (p_internal) else $error("select on internal access");
endmodule : ead_top

// file: sim/ead_ext_mem.sv
// Purpose: far-side model of the external memories and the width strap board
// Assumes: selects arrive as {area6..area2, area0}, active low
// Notes:   records the last select pattern seen on a bus cycle
`timescale 1ns/1ps
module ead_ext_mem #(
   parameter logic [1:0] STRAP = 2'h2
) (
   // clock
   input  wire logic       sys_clk,
   // selects from the decoder
   input  wire logic [5:0] sel_n,
   // board straps
   output logic            width_strap_hi,
   output logic            width_strap_lo,
   // observation
   output logic      [5:0] last_sel_n
);
   // board never presents code 00 on the straps
   assign width_strap_hi = STRAP[1];
   assign width_strap_lo = STRAP[0];
   always_ff @(posedge sys_clk) begin
      if (sel_n != 6'h3F) begin
         last_sel_n <= sel_n;
      end
   end
endmodule : ead_ext_mem

// file: sim/ead_top_bench.sv
// Purpose: self-checking bench for the external area decoder
// Assumes: register byte address is four times the index, straps give 16 bits
// Notes:   apb and access requests change right after rising edges
`timescale 1ns/1ps
module ead_top_bench;
   import ead_pkg::*;
   logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, acc_valid = 1'b0, pready, pslverr, hi, lo, ce_a, ce_b;
   logic [31:0] paddr = '0, pwdata = '0, acc_addr = '0, prdata, rd;
   logic [1:0]  acc_size = 2'h0, acc_bus_width, acc_mem_type;
   logic [2:0]  acc_area;
   logic [7:0]  mrom, sdm_data;
   logic [5:0]  sel_n, last_sel;
   logic        cs0, cs2, cs3, cs4, cs5, cs6, up, intl, sdm2, sdm3, err;
   int          n_mismatch = 0, tests_run = 0, ar;
   assign sel_n = {cs6, cs5, cs4, cs3, cs2, cs0};
   always #12.5 sys_clk = ~sys_clk;
   ead_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_size(acc_size),
      .width_strap_hi(hi), .width_strap_lo(lo), .chip_select_area0_n(cs0),
      .chip_select_area2_n(cs2), .chip_select_area3_n(cs3), .chip_select_area4_n(cs4),
      .chip_select_area5_n(cs5), .chip_select_area6_n(cs6), .card_enable_hi_a_n(ce_a),
      .card_enable_hi_b_n(ce_b), .mask_rom_selects_n(mrom), .acc_area(acc_area),
      .acc_bus_width(acc_bus_width), .acc_mem_type(acc_mem_type), .acc_upper_half(up),
      .acc_internal(intl), .sdram_mode_set_area2(sdm2), .sdram_mode_set_area3(sdm3),
      .sdram_mode_data(sdm_data));
   ead_ext_mem #(.STRAP(2'h2)) mem (.sys_clk(sys_clk), .sel_n(sel_n),
      .width_strap_hi(hi), .width_strap_lo(lo), .last_sel_n(last_sel));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [31:0] ra(input int i);
      return {REG_IDX[i][29:0], 2'b00};
   endfunction : ra
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         close_out();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb
   task automatic acc(input logic [31:0] a, input logic [1:0] sz);
      @(posedge sys_clk);
      acc_valid <= 1'b1;
      acc_addr <= a;
      acc_size <= sz;
      @(posedge sys_clk);
      acc_valid <= 1'b0;
      #1;
   endtask : acc
   task automatic chk_acc(input int a, input logic [1:0] w, input logic [1:0] mt);
      logic [5:0] s = 6'h3F;
      s[a == 0 ? 0 : a - 1] = 1'b0;
      chk("area", a, acc_area);
      chk("selects", s, sel_n);
      chk("width", w, acc_bus_width);
      chk("mem type", mt, acc_mem_type);
      chk("internal", 0, intl);
   endtask : chk_acc
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < REG_NUM; i++) begin
         apb(1'b0, ra(i), 0);
         chk("reset value", {16'h0000, REG_RST[i]}, rd);
      end
      apb(1'b0, 32'h0000_0000, 0);
      chk("unmapped err", 1, err);
      // sdram areas 2 and 3 both 16 bits, card areas 8 or 16, no data pin used as a port
      apb(1'b1, ra(SLOT_BUS_CTRL_TWO), 32'h0000_27A0);
      apb(1'b0, ra(SLOT_BUS_CTRL_TWO), 0);
      chk("bus ctrl two", 32'h0000_27A0, rd);
      $display("test registers done");
      // bits 31..29 sweep shadows 0 to 6, odd n hits the top of the area; area 7 never used
      for (int ai = 0; ai < 6; ai++) begin
         for (int n = 0; n < 7; n++) begin
            ar = (ai == 0) ? 0 : ai + 1;
            acc(ar * 32'h0400_0000 + n * 32'h2000_0000 + (n % 2) * 32'h03FF_FFFC, 2'h2);
            chk_acc(ar, ar == 0 ? 2'h2 : 2'(16'h27A0 >> (2 * ar)), MT_NORM);
         end
      end
      @(posedge sys_clk);
      #1;
      chk("partner last", 6'h1F, last_sel);
      // valid held two cycles while only the shadow bits move
      @(posedge sys_clk);
      acc_valid <= 1'b1;
      acc_addr <= 32'h1000_0000;
      acc_size <= 2'h2;
      @(posedge sys_clk);
      acc_addr <= 32'h7000_0000;
      @(posedge sys_clk);
      acc_valid <= 1'b0;
      #1;
      chk_acc(4, 2'h3, MT_NORM);
      acc(32'hA400_0000, 2'h2);
      chk("on-chip selects", 6'h3F, sel_n);
      chk("on-chip flag", 1, intl);
      $display("test areas done");
      apb(1'b1, ra(SLOT_MEM_TYPE), 32'h0000_0007);
      apb(1'b1, ra(SLOT_CARD_IF), 32'h0000_0001);
      apb(1'b1, ra(3), 32'h0000_0003);
      acc(32'h0980_0000, 2'h1);
      chk_acc(2, 2'h2, MT_SDRAM);
      chk("mask rom", 8'hF7, mrom);
      acc(32'h0180_0000, 2'h1);
      chk("mask rom area0", 8'hFF, mrom);
      chk("area0 burst", MT_BURST, acc_mem_type);
      acc(32'h1600_0000, 2'h1);
      chk_acc(5, 2'h1, MT_CARD);
      chk("card enable a", 0, ce_a);
      chk("upper half", 1, up);
      acc(32'h1400_0000, SZ_BYTE);
      chk("card enable a byte", 1, ce_a);
      chk("lower half", 0, up);
      acc(32'h1800_0001, SZ_BYTE);
      chk_acc(6, 2'h2, MT_NORM);
      chk("card enable b", 1, ce_b);
      apb(1'b1, ra(SLOT_CARD_IF), 32'h0000_0003);
      acc(32'h1A00_0002, 2'h1);
      chk_acc(6, 2'h2, MT_CARD);
      chk("card enable b word", 0, ce_b);
      $display("test card and rom done");
      apb(1'b1, 32'hFFFF_7FFC, 32'h0000_00A5);
      #1;
      chk("mode set 2", 1, sdm2);
      chk("mode data 2", 8'hA5, sdm_data);
      chk("mode set 3 idle", 0, sdm3);
      apb(1'b1, 32'hFFFF_8000, 32'h0000_003C);
      #1;
      chk("mode set 3", 1, sdm3);
      chk("mode data 3", 8'h3C, sdm_data);
      $display("test mode set done");
      close_out();
   end
endmodule : ead_top_bench
